//--- hw/ibsc_defs.svh
// Offsets, field positions and reset values of the boot and security block
`ifndef IBSC_DEFS_SVH
`define IBSC_DEFS_SVH

// Special function register addresses
`define IBSC_CTRL_ADDR     8'hbf
`define IBSC_UNLOCK_ADDR   8'hf6

// Unlock sequence values
`define IBSC_UNLOCK_KEY1   8'h87
`define IBSC_UNLOCK_KEY2   8'h59

// Control register fields
`define IBSC_BIT_SWRST     7
`define IBSC_BIT_EXEC      5
`define IBSC_BIT_AUX       4
`define IBSC_BIT_ONE       3
`define IBSC_BIT_BOOTSEL   1
`define IBSC_BIT_PROGEN    0

// Security register location, erased value and fields
`define IBSC_SEC_ADDR      16'hffff
`define IBSC_SEC_ERASED    8'hff
`define IBSC_SEC_LOCK      1
`define IBSC_SEC_TBRD      2
`define IBSC_SEC_ENC       3
`define IBSC_SEC_GAIN      7

`endif

//--- hw/ibsc_pkg.sv
// Types shared by the boot and security block
package ibsc_pkg;

    // Progress of the two-value unlock sequence
    typedef enum logic [1:0] {
        IBSC_LOCKED,
        IBSC_HALF,
        IBSC_OPEN
    } ibsc_unlock_t;

    // Special function register access from the CPU
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } ibsc_sfr_req_t;

    // Programmer access to the security register
    typedef struct packed {
        logic        prog_mode;
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
        logic        erase_all;
    } ibsc_prog_req_t;

    // Table-read request from the CPU
    typedef struct packed {
        logic        valid;
        logic        from_external;
        logic        to_internal;
    } ibsc_tbrd_req_t;

    // Whole state of the block
    typedef struct packed {
        ibsc_unlock_t unlock;
        logic         strap_done;
        logic         swrst;
        logic         aux;
        logic         bootsel;
        logic         progen;
        logic         exec;
        logic [7:0]   sec;
        logic         soft_rst_pulse;
        logic [7:0]   sfr_rdata;
        logic [7:0]   prog_rdata;
        logic         prog_rvalid;
        logic         rom_block;
        logic         osc_half;
        logic         tbrd_route_int;
        logic [7:0]   p0_out;
    } ibsc_state_t;

endpackage

//--- hw/ibsc_top.sv
// Boot source, unlock protected control register and security options
`include "ibsc_defs.svh"

module ibsc_top
    import ibsc_pkg::*;
#(
    parameter logic [7:0] ENC_KEY = 8'h5a
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rstn,
    // CPU register port
    input  wire ibsc_sfr_req_t  sfr_req,
    output logic [7:0]          sfr_rdata,
    // CPU power state
    input  wire logic           idle_wake,
    // Boot straps
    input  wire logic           strap_p26,
    input  wire logic           strap_p27,
    input  wire logic           strap_p43,
    // Programmer port
    input  wire ibsc_prog_req_t prog_req,
    output logic [7:0]          prog_rdata,
    output logic                prog_rvalid,
    // Table-read steering
    input  wire ibsc_tbrd_req_t tbrd_req,
    output logic                tbrd_route_internal,
    // Port 0 data path
    input  wire logic [7:0]     p0_data,
    output logic [7:0]          p0_pin_out,
    // Status to the rest of the chip
    output logic                exec_source_flag,
    output logic                aux_ram_enable,
    output logic                soft_reset_pulse,
    output logic                rom_access_block,
    output logic                osc_gain_half
);

    // A zero key leaves the encoder a plain rotation
    if (ENC_KEY == 8'h00) begin : g_key_check
        $error("ENC_KEY must be nonzero");
    end

    localparam ibsc_state_t ST_RESET = '{
        unlock: IBSC_LOCKED,
        sec: `IBSC_SEC_ERASED,
        default: '0
    };

    logic [1:0]  rst_ff;
    logic        rst_sync_n;
    ibsc_state_t st;
    ibsc_state_t nx;
    logic        armed;
    logic        ctrl_wr;
    logic        unl_wr;
    logic        sec_ok;

    // Reading the control register as software sees it
    function automatic logic [7:0] ctrl_view(input ibsc_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[`IBSC_BIT_SWRST]   = s.swrst;
        v[`IBSC_BIT_EXEC]    = s.exec;
        v[`IBSC_BIT_AUX]     = s.aux;
        v[`IBSC_BIT_ONE]     = 1'b1;
        v[`IBSC_BIT_BOOTSEL] = s.bootsel;
        v[`IBSC_BIT_PROGEN]  = s.progen;
        return v;
    endfunction

    // Port 0 scrambler: rotate then mix with the key
    function automatic logic [7:0] encode(input logic [7:0] d);
        return {d[6:0], d[7]} ^ ENC_KEY;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_ff <= 2'b00;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_ff[1];

    // Decodes for the next-state logic; all but sec_ok also feed the checks
    assign armed   = st.swrst && st.bootsel && st.progen;
    assign ctrl_wr = sfr_req.wr && (sfr_req.addr == `IBSC_CTRL_ADDR);
    assign unl_wr  = sfr_req.wr && (sfr_req.addr == `IBSC_UNLOCK_ADDR);
    assign sec_ok  = prog_req.prog_mode
                     && (prog_req.addr == `IBSC_SEC_ADDR)
                     && st.sec[`IBSC_SEC_LOCK];

    // Next state of the whole block
    always_comb begin
        nx = st;
        nx.soft_rst_pulse = 1'b0;
        nx.prog_rvalid    = 1'b0;

        // Straps are caught once, the cycle after reset release
        if (!st.strap_done) begin
            nx.strap_done = 1'b1;
            nx.exec = (!strap_p27 && !strap_p26)
                      || !strap_p43;
        end

        // Unlock sequence; a stray value always closes access
        if (unl_wr) begin
            case (st.unlock)
                IBSC_LOCKED: begin
                    if (sfr_req.wdata == `IBSC_UNLOCK_KEY1) begin
                        nx.unlock = IBSC_HALF;
                    end
                end
                IBSC_HALF: begin
                    if (sfr_req.wdata == `IBSC_UNLOCK_KEY2) begin
                        nx.unlock = IBSC_OPEN;
                    end else if (sfr_req.wdata == `IBSC_UNLOCK_KEY1) begin
                        nx.unlock = IBSC_HALF;
                    end else begin
                        nx.unlock = IBSC_LOCKED;
                    end
                end
                IBSC_OPEN: begin
                    if (sfr_req.wdata == `IBSC_UNLOCK_KEY1) begin
                        nx.unlock = IBSC_HALF;
                    end else if (sfr_req.wdata != `IBSC_UNLOCK_KEY2) begin
                        nx.unlock = IBSC_LOCKED;
                    end
                end
                default: begin
                    nx.unlock = IBSC_LOCKED;
                end
            endcase
        end

        // Control writes land only while access is open
        if (ctrl_wr && st.unlock == IBSC_OPEN) begin
            nx.swrst   = sfr_req.wdata[`IBSC_BIT_SWRST];
            nx.aux     = sfr_req.wdata[`IBSC_BIT_AUX];
            nx.bootsel = sfr_req.wdata[`IBSC_BIT_BOOTSEL];
            nx.progen  = sfr_req.wdata[`IBSC_BIT_PROGEN];
        end

        // Wake from idle: reset when armed, else switch to loader if progen is set
        if (idle_wake) begin
            if (armed) begin
                nx.soft_rst_pulse = 1'b1;
                nx.exec    = 1'b0;
                nx.swrst   = 1'b0;
                nx.aux     = 1'b0;
                nx.bootsel = 1'b0;
                nx.progen  = 1'b0;
                nx.unlock  = IBSC_LOCKED;
            end else if (st.progen) begin
                nx.exec = 1'b1;
            end
        end

        // Register reads; unmapped addresses answer zero
        if (sfr_req.rd) begin
            if (sfr_req.addr == `IBSC_CTRL_ADDR) begin
                nx.sfr_rdata = ctrl_view(st);
            end else begin
                nx.sfr_rdata = 8'h00;
            end
        end

        // Security bits only fall; erase-all is the way back up
        if (prog_req.erase_all) begin
            nx.sec = `IBSC_SEC_ERASED;
        end else if (prog_req.wr && sec_ok) begin
            nx.sec = st.sec & prog_req.wdata;
        end

        // Reads hide the register once the lock bit is clear
        if (prog_req.rd) begin
            nx.prog_rvalid = 1'b1;
            nx.prog_rdata  = sec_ok ? st.sec : 8'h00;
        end

        // Option outputs follow the stored security bits
        nx.rom_block = !st.sec[`IBSC_SEC_LOCK];
        nx.osc_half  = !st.sec[`IBSC_SEC_GAIN];

        // External code may not read inside while restricted
        nx.tbrd_route_int = tbrd_req.valid && tbrd_req.to_internal
            && (!tbrd_req.from_external
                || st.sec[`IBSC_SEC_TBRD]);

        // Encryption is active low in the option byte
        nx.p0_out = st.sec[`IBSC_SEC_ENC] ? p0_data
                                          : encode(p0_data);
    end

    // The single state register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= ST_RESET;
        end else begin
            st <= nx;
        end
    end

    // Outputs straight from the state register
    assign sfr_rdata           = st.sfr_rdata;
    assign prog_rdata          = st.prog_rdata;
    assign prog_rvalid         = st.prog_rvalid;
    assign tbrd_route_internal = st.tbrd_route_int;
    assign p0_pin_out          = st.p0_out;
    assign exec_source_flag    = st.exec;
    assign aux_ram_enable      = st.aux;
    assign soft_reset_pulse    = st.soft_rst_pulse;
    assign rom_access_block    = st.rom_block;
    assign osc_gain_half       = st.osc_half;

    // Checks, all on the released reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    a_ctrl_write_closed: assert property (
        (ctrl_wr && st.unlock != IBSC_OPEN && !idle_wake)
        |=> $stable(ctrl_view(st)))
        else $error("closed control write changed bits");

    a_unlock_opens: assert property (
        (unl_wr && sfr_req.wdata == `IBSC_UNLOCK_KEY1
         && st.unlock == IBSC_LOCKED && !idle_wake)
        ##1 (unl_wr && sfr_req.wdata == `IBSC_UNLOCK_KEY2 && !idle_wake)
        |=> st.unlock == IBSC_OPEN)
        else $error("unlock pair did not open access");

    a_unlock_closes: assert property (
        (unl_wr && sfr_req.wdata != `IBSC_UNLOCK_KEY1
         && sfr_req.wdata != `IBSC_UNLOCK_KEY2)
        |=> st.unlock == IBSC_LOCKED)
        else $error("stray unlock value left access open");

    a_exec_readback: assert property (
        (sfr_req.rd && sfr_req.addr == `IBSC_CTRL_ADDR)
        |=> sfr_rdata[`IBSC_BIT_EXEC] == $past(st.exec))
        else $error("exec flag read back wrong");

    a_aux_enable: assert property (
        (ctrl_wr && st.unlock == IBSC_OPEN && !idle_wake)
        |=> aux_ram_enable == $past(sfr_req.wdata[`IBSC_BIT_AUX]))
        else $error("aux RAM enable did not follow write");

    a_soft_reset: assert property (
        (armed && idle_wake)
        |=> soft_reset_pulse && !exec_source_flag ##1 !soft_reset_pulse)
        else $error("soft reset not taken to application");

    a_enter_loader: assert property (
        (st.progen && !armed && idle_wake && st.strap_done)
        |=> exec_source_flag)
        else $error("no switch to loader on wake");

    a_sec_only_falls: assert property (
        !prog_req.erase_all |=> (st.sec & ~$past(st.sec)) == 8'h00)
        else $error("security bit rose without erase");

    a_sec_erase: assert property (
        prog_req.erase_all |=> st.sec == `IBSC_SEC_ERASED)
        else $error("erase-all did not restore bits");

    a_lock_blocks: assert property (
        (!st.sec[`IBSC_SEC_LOCK] && !prog_req.erase_all)
        |=> rom_access_block ##1 rom_access_block)
        else $error("lock bit did not block access");

    a_tbrd_restrict: assert property (
        (tbrd_req.valid && tbrd_req.from_external
         && !st.sec[`IBSC_SEC_TBRD])
        |=> !tbrd_route_internal)
        else $error("restricted table read reached inside");

    a_gain_half: assert property (
        osc_gain_half == !$past(st.sec[`IBSC_SEC_GAIN]))
        else $error("oscillator gain does not follow bit");

endmodule

//--- bench/ibsc_strap_model.sv
// Boot strap switches with their pull-up resistors
module ibsc_strap_model (
    // Switch presses from the bench, high = pressed, order p43 p27 p26
    input  wire logic [2:0] press,
    // Strap pins
    output logic            strap_p43,
    output logic            strap_p27,
    output logic            strap_p26
);
    timeunit 1ns;
    timeprecision 100ps;

    // An open switch leaves the pin on its pull-up, so idle is inactive
    assign strap_p43 = !press[2];
    assign strap_p27 = !press[1];
    assign strap_p26 = !press[0];
endmodule

//--- bench/ibsc_top_bench.sv
// Self-checking bench for the boot and security block
`include "ibsc_defs.svh"

module ibsc_top_bench
    import ibsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] KEY = 8'h3c;
    localparam logic [7:0] CTL = `IBSC_CTRL_ADDR;
    localparam logic [7:0] UNL = `IBSC_UNLOCK_ADDR;

    // Stimulus and observed signals
    logic           clk = 1'b0;
    logic           rstn = 1'b0;
    ibsc_sfr_req_t  sfr_req = '0;
    ibsc_prog_req_t prog_req = '0;
    ibsc_tbrd_req_t tbrd_req = '0;
    logic           idle_wake = 1'b0;
    logic           pm = 1'b0;
    logic [2:0]     press = 3'b000;
    logic [7:0]     p0_data = 8'h00;
    logic           strap_p26, strap_p27, strap_p43;
    logic [7:0]     sfr_rdata, prog_rdata, p0_pin_out;
    logic           prog_rvalid, tbrd_route_internal, exec_source_flag;
    logic           aux_ram_enable, soft_reset_pulse;
    logic           rom_access_block, osc_gain_half;
    int             mismatches = 0;
    int             num_checks = 0;
    // Rows: strap presses {p43, p27, p26} beside expected loader boot
    logic [3:0]     rows [8] = '{4'h0, 4'h2, 4'h4, 4'h7,
                                 4'h9, 4'hb, 4'hd, 4'hf};

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    ibsc_top #(.ENC_KEY(KEY)) i_ibsc_top (
        .clk, .rstn, .sfr_req, .sfr_rdata, .idle_wake,
        .strap_p26, .strap_p27, .strap_p43,
        .prog_req, .prog_rdata, .prog_rvalid,
        .tbrd_req, .tbrd_route_internal, .p0_data, .p0_pin_out,
        .exec_source_flag, .aux_ram_enable, .soft_reset_pulse,
        .rom_access_block, .osc_gain_half
    );

    ibsc_strap_model i_ibsc_strap_model (
        .press, .strap_p43, .strap_p27, .strap_p26
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Switches stay pressed past the strap sample, then are let go
    task automatic do_reset(input logic [2:0] pr);
        @(negedge clk);
        rstn = 1'b0;
        press = pr;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        press = 3'b000;
    endtask

    // One-cycle register strobe; read data is settled on return
    task automatic sfr(input logic [7:0] a, input logic [7:0] d,
                       input logic rd);
        @(negedge clk);
        sfr_req = '{a, !rd, rd, d};
        @(negedge clk);
        sfr_req = '{a, 1'b0, 1'b0, d};
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        sfr(a, 8'h00, 1'b1);
        chk(sfr_rdata, exp);
    endtask

    task automatic unlock();
        sfr(UNL, `IBSC_UNLOCK_KEY1, 1'b0);
        sfr(UNL, `IBSC_UNLOCK_KEY2, 1'b0);
    endtask

    // Programmer strobe at the security location
    task automatic prg(input logic w, input logic e, input logic [7:0] d);
        @(negedge clk);
        prog_req = '{pm, `IBSC_SEC_ADDR, w, !w && !e, d, e};
        @(negedge clk);
        prog_req = '{pm, `IBSC_SEC_ADDR, 1'b0, 1'b0, d, 1'b0};
    endtask

    task automatic prd(input logic [7:0] exp);
        prg(1'b0, 1'b0, 8'h00);
        chk(prog_rvalid, 8'h01);
        chk(prog_rdata, exp);
    endtask

    task automatic wake();
        @(negedge clk);
        idle_wake = 1'b1;
        @(negedge clk);
        idle_wake = 1'b0;
    endtask

    // Cut a hang short well beyond the expected run of some 180 cycles
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        foreach (rows[i]) begin
            do_reset(rows[i][3:1]);
            chk(exec_source_flag, rows[i][0]);
            rdc(CTL, {2'b00, rows[i][0], 5'h08});
        end
        do_reset(3'b000);
        chk(exec_source_flag, 8'h00);
        rdc(8'h80, 8'h00);
        // Closed access ignores writes; a stray value breaks the sequence
        sfr(CTL, 8'h10, 1'b0);
        sfr(UNL, `IBSC_UNLOCK_KEY1, 1'b0);
        sfr(UNL, 8'h12, 1'b0);
        sfr(UNL, `IBSC_UNLOCK_KEY2, 1'b0);
        sfr(CTL, 8'h10, 1'b0);
        rdc(CTL, 8'h08);
        unlock();
        sfr(CTL, 8'h10, 1'b0);
        rdc(CTL, 8'h18);
        chk(aux_ram_enable, 8'h01);
        sfr(CTL, 8'h00, 1'b0);
        chk(aux_ram_enable, 8'h00);
        sfr(UNL, 8'h00, 1'b0);
        sfr(CTL, 8'h10, 1'b0);
        rdc(CTL, 8'h08);
        // Security register only in programming mode
        prg(1'b1, 1'b0, 8'h7f);
        prd(8'h00);
        pm = 1'b1;
        prd(8'hff);
        tbrd_req = '{1'b1, 1'b1, 1'b1};
        p0_data = 8'ha5;
        @(negedge clk);
        chk(tbrd_route_internal, 8'h01);
        chk(p0_pin_out, p0_data);
        prg(1'b1, 1'b0, 8'h7f);
        repeat (2) @(negedge clk);
        chk(osc_gain_half, 8'h01);
        prg(1'b1, 1'b0, 8'hff);
        prd(8'h7f);
        prg(1'b1, 1'b0, 8'hf3);
        repeat (2) @(negedge clk);
        chk(tbrd_route_internal, 8'h00);
        chk(p0_pin_out, {p0_data[6:0], p0_data[7]} ^ KEY);
        tbrd_req = '{1'b1, 1'b0, 1'b1};
        @(negedge clk);
        chk(tbrd_route_internal, 8'h01);
        // Programming entry on wake, then the software reset procedure
        unlock();
        sfr(CTL, 8'h01, 1'b0);
        wake();
        chk(exec_source_flag, 8'h01);
        rdc(CTL, 8'h29);
        sfr(CTL, 8'h83, 1'b0);
        wake();
        chk(soft_reset_pulse, 8'h01);
        chk(exec_source_flag, 8'h00);
        @(negedge clk);
        chk(soft_reset_pulse, 8'h00);
        sfr(CTL, 8'h10, 1'b0);
        rdc(CTL, 8'h08);
        prd(8'h73);
        chk(p0_pin_out, {p0_data[6:0], p0_data[7]} ^ KEY);
        prg(1'b0, 1'b1, 8'h00);
        prd(8'hff);
        @(negedge clk);
        chk(p0_pin_out, p0_data);
        chk(osc_gain_half, 8'h00);
        // Lock bit shuts out every later access until erase-all
        prg(1'b1, 1'b0, 8'hfd);
        repeat (2) @(negedge clk);
        chk(rom_access_block, 8'h01);
        prd(8'h00);
        prg(1'b1, 1'b0, 8'h7f);
        repeat (2) @(negedge clk);
        chk(osc_gain_half, 8'h00);
        prg(1'b0, 1'b1, 8'h00);
        prd(8'hff);
        // Read valid is a single pulse; erase lifts the block again
        @(negedge clk);
        chk(prog_rvalid, 8'h00);
        chk(rom_access_block, 8'h00);
        print_verdict();
    end
endmodule
